// [logic/bsaalu_pkg.sv]
// constants, opcodes and carrier types of the shift/arith execution unit
// assumes one core clock; the decode stage supplies one request per cycle
package bsaalu_pkg;

    localparam int BSAALU_W = 32;
    localparam int BSAALU_FRAC_U_SHIFT = 16;
    localparam int BSAALU_FRAC_S_SHIFT = 14;
    localparam int BSAALU_DFIELD_LSB = 9;
    localparam int BSAALU_SFIELD_LSB = 0;
    localparam int BSAALU_RFIELD_LSB = 19;
    localparam logic [31:0] BSAALU_SCR_FWD_MASK = 32'h0001_0001;
    localparam logic [31:0] BSAALU_SCR_REV_MASK = 32'h8000_8000;
    localparam logic BSAALU_CARRY_RST = 1'b0;
    localparam logic BSAALU_ZERO_RST = 1'b0;
    localparam logic [2:0] BSAALU_LANE_RST = 3'h0;

    typedef enum logic [5:0] {
        color_squeeze, rotate_left, rotate_right, shift_arith_left,
        shift_arith_right, shift_left_logical, shift_right_logical,
        byte_rotate_in, nibble_rotate_in, word_rotate_in,
        prefix_get_byte_sel, prefix_get_nibble_sel, prefix_get_word_sel,
        frac_mul_unsigned, frac_mul_signed,
        put_byte_lane, put_nibble_lane, put_word_lane,
        prefix_put_byte_sel, prefix_put_nibble_sel, prefix_put_word_sel,
        put_dest_field, put_src_field, put_result_field,
        scramble_forward, scramble_reverse,
        sign_extend_from, zero_extend_from, bit_deal_bytes, bit_deal_words,
        minus, minus_reverse, minus_signed, minus_extended,
        minus_signed_extended, addsub_by_carry, addsub_by_not_carry,
        addsub_by_zero, addsub_by_not_zero,
        test_and, test_and_not, bit_probe, bit_probe_inv,
        flag_carry_to_reg, flag_not_carry_to_reg,
        flag_zero_to_reg, flag_not_zero_to_reg
    } bsaalu_op_t;

    typedef enum logic [1:0] {
        flag_keep, write_carry_flag, write_zero_flag, write_both_flags
    } bsaalu_flag_wr_t;

    typedef enum logic [2:0] {
        probe_none, probe_write, probe_or, probe_and, probe_xor
    } bsaalu_probe_t;

    typedef struct packed {
        logic valid;
        bsaalu_op_t op;
        logic [31:0] d;
        logic [31:0] s;
        logic [2:0] lane;
        logic from_prefix;
        bsaalu_flag_wr_t flag_wr;
        bsaalu_probe_t probe_mod;
        logic probe_zero;
    } bsaalu_req_t;

    typedef struct packed {
        logic valid;
        logic wr_en;
        logic [31:0] result;
        logic next_s_valid;
        logic [31:0] next_s;
    } bsaalu_resp_t;

endpackage

// [logic/bsaalu_core.sv]
// execution unit: shifts, lane moves, scrambles, subtracts, tests, flags
// assumes requests synchronous to ref_clk_i, answered one cycle later
`timescale 1ns/1ps
`default_nettype none
module bsaalu_core
    import bsaalu_pkg::*;
(
    input wire logic ref_clk_i,          // core clock, 100 MHz
    input wire logic rst_b_i,            // async reset, active low
    input wire bsaalu_req_t req_i,       // instruction and operands
    output bsaalu_resp_t resp_o,         // registered result
    output logic carry_o,                // carry flag state
    output logic zero_o                  // zero flag state
);

    bsaalu_resp_t resp_r;
    logic carry_r;
    logic zero_r;
    logic [2:0] get_sel_r;
    logic get_pend_r;
    logic [2:0] put_sel_r;
    logic put_pend_r;

    bsaalu_resp_t resp_nxt;
    logic c_calc;
    logic z_calc;
    logic [31:0] d;
    logic [31:0] s;
    logic [4:0] n;
    logic [4:0] n_neg;
    logic [4:0] n_dec;
    logic [63:0] wide_l;
    logic [63:0] wide_r;
    logic c_left;
    logic c_right;
    logic [2:0] get_lane;
    logic [2:0] put_lane;
    logic [31:0] s_shr;
    logic [31:0] low_mask;
    logic [32:0] diff_u;
    logic [32:0] diff_s;
    logic [32:0] diff_x;
    logic [32:0] diff_sx;
    logic [32:0] sum_s;
    logic [31:0] tst;
    logic probe_bit;
    logic cond_sub;
    logic [31:0] prod_u;
    logic signed [31:0] prod_s;
    logic [31:0] deal_b;
    logic [31:0] deal_w;

    assign d = req_i.d;
    assign s = req_i.s;
    assign n = s[4:0];
    assign n_neg = 5'd0 - n;
    assign n_dec = n - 5'd1;

    // every fourth bit into bytes, even/odd bits into words
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_deal
            assign deal_b[gi] = d[4 * (gi % 8) + gi / 8];
            assign deal_w[gi] = d[2 * (gi % 16) + gi / 16];
        end
    endgenerate

    always_comb
    begin
        get_lane = get_pend_r ? get_sel_r : BSAALU_LANE_RST;
        put_lane = put_pend_r ? put_sel_r : BSAALU_LANE_RST;
        if (!req_i.from_prefix)
        begin
            get_lane = req_i.lane;
        end
        if (!req_i.from_prefix)
        begin
            put_lane = req_i.lane;
        end
    end

    always_comb
    begin
        wide_l = 64'h0000_0000_0000_0000;
        wide_r = 64'h0000_0000_0000_0000;
        unique case (req_i.op)
            rotate_left: wide_l = {d, d} << n;
            shift_arith_left: wide_l = {d, {32{d[0]}}} << n;
            rotate_right: wide_r = {d, d} >> n;
            shift_arith_right: wide_r = {{32{d[31]}}, d} >> n;
            shift_right_logical: wide_r = {32'h0000_0000, d} >> n;
            default: wide_l = {d, 32'h0000_0000} << n;
        endcase
        c_left = (n == 5'd0) ? d[31] : d[n_neg];
        c_right = (n == 5'd0) ? d[0] : d[n_dec];
    end

    always_comb
    begin
        s_shr = 32'h0000_0000;
        unique case (req_i.op)
            byte_rotate_in: s_shr = s >> {get_lane[1:0], 3'b000};
            nibble_rotate_in: s_shr = s >> {get_lane, 2'b00};
            default: s_shr = s >> {get_lane[0], 4'b0000};
        endcase
        low_mask = (32'h0000_0002 << n) - 32'h0000_0001;
        diff_u = {1'b0, d} - {1'b0, s};
        diff_s = {d[31], d} - {s[31], s};
        diff_x = {1'b0, d} - {1'b0, s} - {32'h0000_0000, carry_r};
        diff_sx = {d[31], d} - {s[31], s} - {32'h0000_0000, carry_r};
        unique case (req_i.op)
            addsub_by_carry: cond_sub = carry_r;
            addsub_by_not_carry: cond_sub = !carry_r;
            addsub_by_zero: cond_sub = zero_r;
            default: cond_sub = !zero_r;
        endcase
        sum_s = cond_sub ? diff_s : ({d[31], d} + {s[31], s});
        tst = (req_i.op == test_and_not) ? (d & ~s) : (d & s);
        probe_bit = d[n] ^ (req_i.op == bit_probe_inv);
        prod_u = d[15:0] * s[15:0];
        prod_s = $signed(d[15:0]) * $signed(s[15:0]);
    end

    always_comb
    begin
        resp_nxt = '0;
        resp_nxt.valid = req_i.valid;
        resp_nxt.wr_en = 1'b1;
        c_calc = carry_r;
        z_calc = 1'b0;
        unique case (req_i.op)
            color_squeeze: resp_nxt.result =
                {16'h0000, d[31:27], d[23:18], d[15:11]};
            rotate_left, shift_arith_left, shift_left_logical:
            begin
                resp_nxt.result = wide_l[63:32];
                c_calc = c_left;
            end
            rotate_right, shift_arith_right, shift_right_logical:
            begin
                resp_nxt.result = wide_r[31:0];
                c_calc = c_right;
            end
            byte_rotate_in: resp_nxt.result = {d[23:0], s_shr[7:0]};
            nibble_rotate_in: resp_nxt.result = {d[27:0], s_shr[3:0]};
            word_rotate_in: resp_nxt.result = {d[15:0], s_shr[15:0]};
            prefix_get_byte_sel, prefix_get_nibble_sel,
            prefix_get_word_sel, prefix_put_byte_sel,
            prefix_put_nibble_sel, prefix_put_word_sel:
                resp_nxt.wr_en = 1'b0;
            frac_mul_unsigned:
            begin
                resp_nxt.wr_en = 1'b0;
                resp_nxt.next_s_valid = 1'b1;
                resp_nxt.next_s = prod_u >> BSAALU_FRAC_U_SHIFT;
                resp_nxt.result = resp_nxt.next_s;
            end
            frac_mul_signed:
            begin
                resp_nxt.wr_en = 1'b0;
                resp_nxt.next_s_valid = 1'b1;
                resp_nxt.next_s = 32'(prod_s >>> BSAALU_FRAC_S_SHIFT);
                resp_nxt.result = resp_nxt.next_s;
            end
            put_byte_lane: resp_nxt.result =
                (d & ~(32'h0000_00ff << {put_lane[1:0], 3'b000}))
                | ({24'h00_0000, s[7:0]} << {put_lane[1:0], 3'b000});
            put_nibble_lane: resp_nxt.result =
                (d & ~(32'h0000_000f << {put_lane, 2'b00}))
                | ({28'h000_0000, s[3:0]} << {put_lane, 2'b00});
            put_word_lane: resp_nxt.result =
                (d & ~(32'h0000_ffff << {put_lane[0], 4'b0000}))
                | ({16'h0000, s[15:0]} << {put_lane[0], 4'b0000});
            put_dest_field: resp_nxt.result =
                {d[31:18], s[8:0], d[BSAALU_DFIELD_LSB-1:0]};
            put_src_field: resp_nxt.result =
                {d[31:BSAALU_SFIELD_LSB+9], s[8:0]};
            put_result_field: resp_nxt.result =
                {d[31:28], s[8:0], d[BSAALU_RFIELD_LSB-1:0]};
            scramble_forward: resp_nxt.result =
                {d[30:0], d[31]} ^ BSAALU_SCR_FWD_MASK;
            scramble_reverse: resp_nxt.result =
                {d[0], d[31:1]} ^ BSAALU_SCR_REV_MASK;
            sign_extend_from:
            begin
                resp_nxt.result = d[n] ? (d | ~low_mask) : (d & low_mask);
                c_calc = resp_nxt.result[31];
            end
            zero_extend_from:
            begin
                resp_nxt.result = d & low_mask;
                c_calc = resp_nxt.result[31];
            end
            bit_deal_bytes: resp_nxt.result = deal_b;
            bit_deal_words: resp_nxt.result = deal_w;
            minus:
            begin
                resp_nxt.result = diff_u[31:0];
                c_calc = diff_u[32];
            end
            minus_reverse:
            begin
                resp_nxt.result = s - d;
                c_calc = (s < d);
            end
            minus_signed:
            begin
                resp_nxt.result = diff_s[31:0];
                c_calc = diff_s[32];
            end
            minus_extended:
            begin
                resp_nxt.result = diff_x[31:0];
                c_calc = diff_x[32];
                z_calc = zero_r & (diff_x[31:0] == 32'h0000_0000);
            end
            minus_signed_extended:
            begin
                resp_nxt.result = diff_sx[31:0];
                c_calc = diff_sx[32];
                z_calc = zero_r & (diff_sx[31:0] == 32'h0000_0000);
            end
            addsub_by_carry, addsub_by_not_carry,
            addsub_by_zero, addsub_by_not_zero:
            begin
                resp_nxt.result = sum_s[31:0];
                c_calc = sum_s[32];
            end
            test_and, test_and_not:
            begin
                resp_nxt.wr_en = 1'b0;
                resp_nxt.result = d;
                c_calc = ^tst;
                z_calc = (tst == 32'h0000_0000);
            end
            bit_probe, bit_probe_inv:
            begin
                resp_nxt.wr_en = 1'b0;
                resp_nxt.result = d;
            end
            flag_carry_to_reg: resp_nxt.result = {31'h0, carry_r};
            flag_not_carry_to_reg: resp_nxt.result = {31'h0, !carry_r};
            flag_zero_to_reg: resp_nxt.result = {31'h0, zero_r};
            flag_not_zero_to_reg: resp_nxt.result = {31'h0, !zero_r};
            default: resp_nxt.result = d;
        endcase
        if (req_i.op inside {frac_mul_unsigned, frac_mul_signed})
        begin
            z_calc = (resp_nxt.next_s == 32'h0000_0000);
        end
        else if (!(req_i.op inside {minus_extended, minus_signed_extended,
                test_and, test_and_not}))
        begin
            z_calc = (resp_nxt.result == 32'h0000_0000);
        end
        if (!req_i.valid)
        begin
            resp_nxt.wr_en = 1'b0;
            resp_nxt.next_s_valid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            resp_r <= '0;
        end
        else
        begin
            resp_r <= resp_nxt;
        end
    end

    // carry flag
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            carry_r <= BSAALU_CARRY_RST;
        end
        else if (req_i.valid)
        begin
            if (req_i.op inside {bit_probe, bit_probe_inv})
            begin
                if (!req_i.probe_zero)
                begin
                    unique case (req_i.probe_mod)
                        probe_write: carry_r <= probe_bit;
                        probe_or: carry_r <= carry_r | probe_bit;
                        probe_and: carry_r <= carry_r & probe_bit;
                        probe_xor: carry_r <= carry_r ^ probe_bit;
                        default: carry_r <= carry_r;
                    endcase
                end
            end
            else if (req_i.flag_wr inside {write_carry_flag,
                    write_both_flags})
            begin
                carry_r <= c_calc;
            end
        end
    end

    // zero flag
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            zero_r <= BSAALU_ZERO_RST;
        end
        else if (req_i.valid)
        begin
            if (req_i.op inside {bit_probe, bit_probe_inv})
            begin
                if (req_i.probe_zero)
                begin
                    unique case (req_i.probe_mod)
                        probe_write: zero_r <= probe_bit;
                        probe_or: zero_r <= zero_r | probe_bit;
                        probe_and: zero_r <= zero_r & probe_bit;
                        probe_xor: zero_r <= zero_r ^ probe_bit;
                        default: zero_r <= zero_r;
                    endcase
                end
            end
            else if (req_i.flag_wr inside {write_zero_flag,
                    write_both_flags})
            begin
                zero_r <= z_calc;
            end
        end
    end

    // lane prefixes last only until the next instruction
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            get_sel_r <= BSAALU_LANE_RST;
            get_pend_r <= 1'b0;
            put_sel_r <= BSAALU_LANE_RST;
            put_pend_r <= 1'b0;
        end
        else if (req_i.valid)
        begin
            get_pend_r <= req_i.op inside {prefix_get_byte_sel,
                prefix_get_nibble_sel, prefix_get_word_sel};
            get_sel_r <= req_i.lane;
            put_pend_r <= req_i.op inside {prefix_put_byte_sel,
                prefix_put_nibble_sel, prefix_put_word_sel};
            put_sel_r <= req_i.lane;
        end
    end

    assign resp_o = resp_r;
    assign carry_o = carry_r;
    assign zero_o = zero_r;

endmodule
`default_nettype wire

// [bench/bsaalu_dec_model.sv]
// decode-stage model: hands one request a cycle to the unit
// assumes the bench loads cmd_i just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module bsaalu_dec_model
    import bsaalu_pkg::*;
(
    input wire logic ref_clk_i,    // core clock
    input wire logic rst_b_i,      // async reset, active low
    input wire bsaalu_req_t cmd_i, // next instruction from the bench
    output bsaalu_req_t req_o      // request toward the unit
);
    // launch on the falling edge, half a cycle before sampling
    always_ff @(negedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            req_o <= '0;
        else
        begin
            req_o <= cmd_i;
            // idle operands toggle so nothing leans on stale values
            if (!cmd_i.valid)
            begin
                req_o.d <= ~req_o.d;
                req_o.s <= ~req_o.s;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/bsaalu_core_sva.sv]
// port assertions of the shift/arith execution unit
// assumes registered answers one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module bsaalu_core_sva
    import bsaalu_pkg::*;
(
    input wire logic ref_clk_i,      // core clock
    input wire logic rst_b_i,        // async reset, active low
    input wire bsaalu_req_t req_i,   // request
    input wire bsaalu_resp_t resp_o, // answer
    input wire logic carry_o,        // carry flag
    input wire logic zero_o          // zero flag
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_keep;
        (!req_i.valid || (req_i.flag_wr == flag_keep &&
            !(req_i.op inside {bit_probe, bit_probe_inv})))
        |=> $stable(carry_o) && $stable(zero_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("flags moved without a write modifier");
    property p_squeeze;
        req_i.valid && req_i.op == color_squeeze |=> resp_o.result ==
            {16'h0000, $past(req_i.d[31:27]), $past(req_i.d[23:18]),
            $past(req_i.d[15:11])};
    endproperty
    a_squeeze: assert property (p_squeeze)
        else $error("color squeeze result wrong");
    property p_ror;
        req_i.valid && req_i.op == rotate_right |=> resp_o.result ==
            (($past(req_i.d) >> $past(req_i.s[4:0])) |
            ($past(req_i.d) << (6'd32 - $past(req_i.s[4:0]))));
    endproperty
    a_ror: assert property (p_ror)
        else $error("rotate right result wrong");
    property p_shl0;
        req_i.valid && req_i.op == shift_left_logical &&
            req_i.s[4:0] == 5'h00 &&
            req_i.flag_wr inside {write_carry_flag, write_both_flags}
        |=> carry_o == $past(req_i.d[31]);
    endproperty
    a_shl0: assert property (p_shl0)
        else $error("zero count left shift carry wrong");
    property p_borrow;
        req_i.valid && req_i.op == minus &&
            req_i.flag_wr inside {write_carry_flag, write_both_flags}
        |=> carry_o == ($past(req_i.d) < $past(req_i.s));
    endproperty
    a_borrow: assert property (p_borrow)
        else $error("subtract borrow wrong");
    property p_test;
        req_i.valid && req_i.op inside {test_and, test_and_not}
        |=> !resp_o.wr_en && resp_o.result == $past(req_i.d);
    endproperty
    a_test: assert property (p_test)
        else $error("test altered destination");
    property p_flagreg;
        req_i.valid && req_i.op == flag_carry_to_reg
        |=> resp_o.result == {31'h0000_0000, $past(carry_o)};
    endproperty
    a_flagreg: assert property (p_flagreg)
        else $error("carry to register wrong");
    property p_frac;
        req_i.valid && req_i.op == frac_mul_unsigned
        |=> resp_o.next_s_valid && resp_o.next_s ==
            (({16'h0000, $past(req_i.d[15:0])} *
            {16'h0000, $past(req_i.s[15:0])}) >> 16);
    endproperty
    a_frac: assert property (p_frac)
        else $error("unsigned scale wrong");
    c_prefix: cover property (req_i.valid && req_i.from_prefix ##1
        resp_o.valid);
    c_scramble: cover property (req_i.valid && req_i.op == scramble_forward);
    c_frac: cover property (resp_o.next_s_valid);
endmodule
bind bsaalu_core bsaalu_core_sva u_sva (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .req_i(req_i),
    .resp_o(resp_o),
    .carry_o(carry_o),
    .zero_o(zero_o)
);
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the shift/arith execution unit
// assumes the decode model launches requests on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bsaalu_pkg::*;
;
    logic ref_clk_i;
    logic rst_b_i;
    bsaalu_req_t cmd;
    bsaalu_req_t req;
    bsaalu_resp_t resp;
    logic carry;
    logic zero;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed;
    bsaalu_op_t ops[21] = '{rotate_left, rotate_right, shift_arith_left,
        shift_arith_right, shift_left_logical, shift_right_logical,
        color_squeeze, minus, minus_reverse, minus_signed, minus_extended,
        minus_signed_extended, addsub_by_carry, addsub_by_zero,
        sign_extend_from, zero_extend_from, test_and, bit_deal_bytes,
        flag_carry_to_reg, frac_mul_unsigned, frac_mul_signed};
    bsaalu_dec_model u_dec (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .cmd_i(cmd), .req_o(req));
    bsaalu_core dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req),
        .resp_o(resp), .carry_o(carry), .zero_o(zero));
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 2000)
        begin
            n_fail = n_fail + 1;
            results();
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_w(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(string nm, logic e, logic g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    // load a request and wait for its answer to settle
    task automatic run(bsaalu_req_t r);
        cmd = r;
        @(posedge ref_clk_i);
        #1;
    endtask
    function automatic bsaalu_req_t mk(bsaalu_op_t op, logic [31:0] d,
        logic [31:0] s, logic [2:0] ln, logic pf, bsaalu_flag_wr_t fw);
        bsaalu_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.d = d;
        r.s = s;
        r.lane = ln;
        r.from_prefix = pf;
        r.flag_wr = fw;
        return r;
    endfunction
    // returns {carry checked, carry, zero, result}
    function automatic logic [34:0] model(bsaalu_op_t op, logic [31:0] d,
        logic [31:0] s, logic c, logic z);
        logic [4:0] n;
        logic [63:0] w;
        logic [32:0] t;
        logic [31:0] m;
        logic cv;
        logic zo;
        n = s[4:0];
        w = '0;
        t = '0;
        cv = 1'b1;
        m = 32'hFFFF_FFFF >> (5'd31 - n);
        case (op)
            rotate_left: w = {d, d} << n;
            shift_arith_left: w = {d, {32{d[0]}}} << n;
            shift_left_logical: w = {d, 32'h0000_0000} << n;
            rotate_right: w = {d, d} >> n;
            shift_arith_right: w = {{32{d[31]}}, d} >> n;
            shift_right_logical: w = {32'h0000_0000, d} >> n;
            color_squeeze: t = {c, 16'h0000, d[31:27], d[23:18], d[15:11]};
            minus: t = {1'b0, d} - {1'b0, s};
            minus_reverse: t = {1'b0, s} - {1'b0, d};
            minus_signed: t = {d[31], d} - {s[31], s};
            minus_extended: t = {1'b0, d} - {1'b0, s} - c;
            minus_signed_extended: t = {d[31], d} - {s[31], s} - c;
            addsub_by_carry: t = c ? {d[31], d} - {s[31], s}
                : {d[31], d} + {s[31], s};
            addsub_by_zero: t = z ? {d[31], d} - {s[31], s}
                : {d[31], d} + {s[31], s};
            sign_extend_from: t = {d[n], (d & m) | ({32{d[n]}} & ~m)};
            zero_extend_from: t = {(n == 5'd31) & d[31], d & m};
            test_and: t = {^(d & s), d};
            flag_carry_to_reg: t = {c, 31'h0000_0000, c};
            frac_mul_unsigned: t[31:0] = ({16'h0000, d[15:0]}
                * {16'h0000, s[15:0]}) >> 16;
            frac_mul_signed: t[31:0] = ($signed(d[15:0])
                * $signed(s[15:0])) >>> 14;
            default:
                for (int i = 0; i < 32; i++)
                    t[(i % 4) * 8 + i / 4] = d[i];
        endcase
        if (op inside {rotate_left, shift_arith_left, shift_left_logical})
            t = {n != 0 ? d[6'd32 - n] : d[31], w[63:32]};
        if (op inside {rotate_right, shift_arith_right, shift_right_logical})
            t = {n != 0 ? d[n - 1] : d[0], w[31:0]};
        if (op inside {color_squeeze, bit_deal_bytes, frac_mul_unsigned,
            frac_mul_signed})
            cv = 1'b0;
        zo = (t[31:0] == 32'h0000_0000);
        if (op inside {minus_extended, minus_signed_extended})
            zo = z & zo;
        if (op == test_and)
            zo = ((d & s) == 32'h0000_0000);
        return {cv, t[32], zo, t[31:0]};
    endfunction
    initial
    begin
        bsaalu_req_t r;
        logic [34:0] e;
        logic [31:0] d0;
        logic [31:0] v;
        logic f;
        seed = 87127;
        cmd = '0;
        rst_b_i = 1'b0;
        repeat (10) @(posedge ref_clk_i);
        chk_b("rst_valid", 1'b0, resp.valid);
        chk_b("rst_carry", 1'b0, carry);
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        d0 = $random(seed);
        v = $random(seed);
        run(mk(prefix_get_byte_sel, d0, v, 3'h2, 1'b0, flag_keep));
        chk_b("pre_wr", 1'b0, resp.wr_en);
        run(mk(byte_rotate_in, d0, v, 3'h0, 1'b1, flag_keep));
        chk_w("rot_pre", {d0[23:0], v[23:16]}, resp.result);
        run(mk(byte_rotate_in, d0, v, 3'h0, 1'b1, flag_keep));
        chk_w("rot_nopre", {d0[23:0], v[7:0]}, resp.result);
        run(mk(nibble_rotate_in, d0, v, 3'h7, 1'b0, flag_keep));
        chk_w("rot_nib", {d0[27:0], v[31:28]}, resp.result);
        run(mk(word_rotate_in, d0, v, 3'h1, 1'b0, flag_keep));
        chk_w("rot_word", {d0[15:0], v[31:16]}, resp.result);
        run(mk(prefix_put_nibble_sel, d0, v, 3'h5, 1'b0, flag_keep));
        run(mk(put_nibble_lane, d0, v, 3'h0, 1'b1, flag_keep));
        chk_w("put_pre", {d0[31:24], v[3:0], d0[19:0]}, resp.result);
        run(mk(put_byte_lane, d0, v, 3'h3, 1'b0, flag_keep));
        chk_w("put_byte", {v[7:0], d0[23:0]}, resp.result);
        run(mk(put_dest_field, d0, v, 3'h0, 1'b0, flag_keep));
        chk_w("dfield", {d0[31:18], v[8:0], d0[8:0]}, resp.result);
        run(mk(put_result_field, d0, v, 3'h0, 1'b0, flag_keep));
        chk_w("rfield", {d0[31:28], v[8:0], d0[18:0]}, resp.result);
        run(mk(put_src_field, d0, v, 3'h0, 1'b0, flag_keep));
        chk_w("sfield", {d0[31:9], v[8:0]}, resp.result);
        run(mk(scramble_forward, d0, d0, 3'h0, 1'b0, flag_keep));
        chk_w("scr_step", {d0[30:0], d0[31]} ^ BSAALU_SCR_FWD_MASK,
            resp.result);
        for (int k = 0; k < 2; k++)
        begin
            v = d0;
            repeat (32)
            begin
                run(mk(k ? scramble_reverse : scramble_forward, v, v, 3'h0,
                    1'b0, flag_keep));
                v = resp.result;
            end
            chk_w("scramble", d0, v);
        end
        run(mk(frac_mul_signed, 32'h0000_4000, 32'h0000_C000, 3'h0, 1'b0,
            flag_keep));
        chk_b("ns_valid", 1'b1, resp.next_s_valid);
        chk_w("frac_s", 32'hFFFF_C000, resp.next_s);
        run(mk(minus, 32'h0000_0005, 32'h0000_0007, 3'h0, 1'b0,
            write_both_flags));
        chk_w("walk", 32'hFFFF_FFFE, resp.result);
        run(mk(minus, 32'h0000_0007, 32'h0000_0007, 3'h0, 1'b0, flag_keep));
        chk_b("keep_c", 1'b1, carry);
        chk_b("keep_z", 1'b0, zero);
        run(mk(minus, 32'h0000_0007, 32'h0000_0007, 3'h0, 1'b0,
            write_zero_flag));
        chk_b("z_only", 1'b1, zero);
        chk_b("c_kept", 1'b1, carry);
        for (int k = 0; k < 16; k++)
        begin
            r = mk(k[0] ? bit_probe_inv : bit_probe, $random(seed),
                $random(seed), 3'h0, 1'b0, flag_keep);
            r.probe_mod = bsaalu_probe_t'(k[3:2] + 1);
            r.probe_zero = k[1];
            f = k[1] ? zero : carry;
            case (r.probe_mod)
                probe_write: f = r.d[r.s[4:0]] ^ k[0];
                probe_or: f = f | (r.d[r.s[4:0]] ^ k[0]);
                probe_and: f = f & (r.d[r.s[4:0]] ^ k[0]);
                default: f = f ^ (r.d[r.s[4:0]] ^ k[0]);
            endcase
            run(r);
            chk_b("probe", f, k[1] ? zero : carry);
        end
        for (int i = 0; i < 300; i++)
        begin
            r = mk(i < 42 ? ops[i % 21] : ops[$unsigned($random(seed)) % 21],
                $random(seed), $random(seed), 3'h0, 1'b0, write_both_flags);
            if (i < 42)
                r.s[4:0] = i < 21 ? 5'h00 : 5'h1F;
            e = model(r.op, r.d, r.s, carry, zero);
            run(r);
            chk_w("result", e[31:0], resp.result);
            chk_b("zero", e[32], zero);
            if (e[34])
                chk_b("carry", e[33], carry);
        end
        results();
    end
endmodule
`default_nettype wire
